/* File: mcta_defs.vh */
// Constants for the motion command trigger arbiter: register offsets,
// field positions, reset values and encodings.
// Assumes inclusion by bare name from the design files only.
`ifndef MCTA_DEFS_VH
`define MCTA_DEFS_VH

// Register byte offsets on the plain register port.
`define MCTA_OFF_MODE     8'h00
`define MCTA_OFF_SWSTART  8'h04
`define MCTA_OFF_EVMAP1   8'h08
`define MCTA_OFF_EVMAP2   8'h0C
`define MCTA_OFF_EVMAP3   8'h10
`define MCTA_OFF_EVMAP4   8'h14
`define MCTA_OFF_JUMP     8'h18
`define MCTA_OFF_STATUS   8'h1C

// Field positions.
`define MCTA_JUMP_LSB     16
`define MCTA_JUMP_MSB     23
`define MCTA_ST_BUSY      0
`define MCTA_ST_PEND      1
`define MCTA_ST_CUR_LSB   8
`define MCTA_ST_PCMD_LSB  16
`define MCTA_ST_RANK_LSB  24

// Reset values.
`define MCTA_RST_MODE     2'h0
`define MCTA_RST_EVMAP    14'h0000
`define MCTA_RST_JUMP     8'h00
`define MCTA_RST_WORD     32'h0000_0000

// Interrupt mode settings.
`define MCTA_MODE_IGNORE  2'h0
`define MCTA_MODE_AFTER   2'h1
`define MCTA_MODE_ABORT   2'h2

// Jump codes held at bits 16 to 23 of each command's mode word.
`define MCTA_JMP_STOP     8'h00
`define MCTA_JMP_NEXT     8'hA0
`define MCTA_JMP_PREV     8'hB0
`define MCTA_JMP_LAST     8'h44

// Number of ranked trigger sources and the rank of the idle value.
`define MCTA_NUM_SRC      10
`define MCTA_RANK_NONE    4'hF

`endif

/* File: mcta_edge.v */
// One input conditioner: three-stage synchroniser and edge detector.
// Assumes the input is asynchronous to core_clk.
`default_nettype none

module mcta_edge (
  input  wire core_clk,
  input  wire sys_rst,
  input  wire pin_in,
  output wire level,
  output wire rise,
  output wire fall
);

  reg sync1_r;
  reg sync2_r;
  reg sync3_r;
  reg level_r;

  // Stage one feeds only stage two; a change is taken once stages two and three agree.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        level_r <= sync3_r; // RQ16
      end
    end
  end

  // Edges compare the agreed sample with the previously accepted one.
  assign level = level_r;
  assign rise  = (sync2_r == sync3_r) && sync3_r && !level_r;  // RQ16
  assign fall  = (sync2_r == sync3_r) && !sync3_r && level_r;  // RQ16

endmodule // mcta_edge

`default_nettype wire

/* File: mcta_arbiter.v */
// Trigger arbiter and interrupt control for a stored motion command sequencer.
// Assumes an outside motion engine that runs the started command and pulses
// cmd_done when it completes, applying its own overlap setting on chained starts.
//
// Overview of operation
// [RQ1] Any change of one of the four event inputs raises a command request; the code raises one only if the mapped number is 1 to 68.
// [RQ2] A rising event edge runs the command held in the upper two decimal digits of its map.
// [RQ3] A falling event edge runs the command held in the lower two decimal digits of its map.
// [RQ4] Event inputs one to four each have their own map register, in consecutive order.
// [RQ5] Requests come from a software start register, the hardware start input and the events.
// [RQ6] Ranks are event 1 rise, fall, then events 2 to 4 likewise, then hardware, then software.
// [RQ7] Of simultaneous requests only the best ranked runs and the rest are masked.
// [RQ8] One global interrupt mode decides how every command reacts to new requests.
// [RQ9] Mode 0 drops requests while the chain runs and accepts them once it has ended.
// [RQ10] Mode 1 finishes the running command then starts the request, skipping its jump code.
// [RQ11] Mode 1 marks that start as chained so the engine links it by the overlap setting.
// [RQ12] Mode 1 keeps only the best ranked request seen during execution and runs it next.
// [RQ13] Mode 2 aborts the running command at once and starts the request directly.
// [RQ14] The jump code at bits 16 to 23 of each command decides what follows its completion.
// [RQ15] The six select inputs form a binary command number, first input least significant.
// [RQ16] Event inputs are synchronised and edges found by comparing successive samples.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`default_nettype none
`include "mcta_defs.vh"

module mcta_arbiter #(
  parameter CMD_W   = 7,
  parameter MAP_W   = 14,
  parameter MAX_CMD = 68
) (
  input  wire             core_clk,
  input  wire             sys_rst,
  input  wire [7:0]       reg_addr,
  input  wire [31:0]      reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output wire [31:0]      reg_rdata,
  input  wire [3:0]       event_trigger_inputs,
  input  wire             hw_start_input,
  input  wire [5:0]       cmd_select_inputs,
  input  wire             cmd_done,
  output wire             cmd_start,
  output wire [CMD_W-1:0] cmd_num,
  output wire             cmd_chained,
  output wire             cmd_abort,
  output wire             cmd_busy
);

  // Configuration registers.
  reg  [1:0]       mode_r;
  reg  [CMD_W-1:0] sw_cmd_r;
  reg              sw_req_r;
  reg  [MAP_W-1:0] evmap_r [0:3];
  reg  [7:0]       jump_r  [0:MAX_CMD];
  reg  [CMD_W-1:0] jump_idx_r;
  reg  [31:0]      rdata_r;

  // Sequencer state.
  reg              busy_r;
  reg  [CMD_W-1:0] cur_r;
  reg  [CMD_W-1:0] prev_r;
  reg              pend_r;
  reg  [CMD_W-1:0] pend_cmd_r;
  reg  [3:0]       pend_rank_r;
  reg  [3:0]       last_rank_r;
  reg              start_r;
  reg              abort_r;
  reg              chained_r;
  reg  [CMD_W-1:0] num_r;

  // Conditioned inputs: four events, the hardware start and six select lines.
  wire [10:0]      pins_in;
  wire [10:0]      pin_lvl;
  wire [10:0]      pin_rise;
  wire [10:0]      pin_fall;
  wire [5:0]       sel_code;

  assign pins_in = {cmd_select_inputs, hw_start_input, event_trigger_inputs};

  genvar g;
  generate
    for (g = 0; g < 11; g = g + 1) begin : g_pin
      mcta_edge u_edge (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_in   (pins_in[g]),
        .level    (pin_lvl[g]),
        .rise     (pin_rise[g]),
        .fall     (pin_fall[g])
      );
    end
  endgenerate

  assign sel_code = pin_lvl[10:5]; // RQ15

  // Upper and lower decimal digit pairs of a map value.
  function [CMD_W-1:0] dec_hi;
    input [MAP_W-1:0] v;
    reg   [MAP_W-1:0] t;
    begin
      t      = (v / 14'd100) % 14'd100;
      dec_hi = t[CMD_W-1:0];
    end
  endfunction

  function [CMD_W-1:0] dec_lo;
    input [MAP_W-1:0] v;
    reg   [MAP_W-1:0] t;
    begin
      t      = v % 14'd100;
      dec_lo = t[CMD_W-1:0];
    end
  endfunction

  // A command number of zero or past the table means no request.
  function cmd_ok;
    input [CMD_W-1:0] c;
    begin
      cmd_ok = (c != {CMD_W{1'b0}}) && (c <= MAX_CMD[CMD_W-1:0]);
    end
  endfunction

  // Source vector in rank order: index 0 is rank 1, index 9 is rank 10.
  reg  [`MCTA_NUM_SRC-1:0]       src_v;
  reg  [`MCTA_NUM_SRC*CMD_W-1:0] src_cmd;
  integer k;

  always @* begin
    src_v   = {`MCTA_NUM_SRC{1'b0}};
    src_cmd = {(`MCTA_NUM_SRC*CMD_W){1'b0}};
    for (k = 0; k < 4; k = k + 1) begin
      src_cmd[(2*k)*CMD_W +: CMD_W]   = dec_hi(evmap_r[k]);                  // RQ2
      src_cmd[(2*k+1)*CMD_W +: CMD_W] = dec_lo(evmap_r[k]);                  // RQ3
      src_v[2*k]   = pin_rise[k] && cmd_ok(dec_hi(evmap_r[k]));              // RQ1
      src_v[2*k+1] = pin_fall[k] && cmd_ok(dec_lo(evmap_r[k]));              // RQ1
    end
    src_cmd[8*CMD_W +: CMD_W] = {1'b0, sel_code};
    src_v[8] = pin_rise[4] && cmd_ok({1'b0, sel_code});                      // RQ5
    src_cmd[9*CMD_W +: CMD_W] = sw_cmd_r;
    src_v[9] = sw_req_r && cmd_ok(sw_cmd_r);                                 // RQ5
  end

  // Fixed priority: scanning downward leaves the lowest index standing.
  reg              sel_v;
  reg  [CMD_W-1:0] sel_cmd;
  reg  [3:0]       sel_rank;
  integer i;

  always @* begin
    sel_v    = 1'b0;
    sel_cmd  = {CMD_W{1'b0}};
    sel_rank = `MCTA_RANK_NONE;
    for (i = `MCTA_NUM_SRC - 1; i >= 0; i = i - 1) begin
      if (src_v[i]) begin
        sel_v    = 1'b1;                                                     // RQ7
        sel_cmd  = src_cmd[i*CMD_W +: CMD_W];
        sel_rank = i[3:0];                                                   // RQ6
      end
    end
  end

  // What follows a completed command when nothing else is queued.
  reg  [7:0]       jcode;
  reg              jmp_v;
  reg  [CMD_W-1:0] jmp_cmd;

  always @* begin
    jcode   = (cur_r <= MAX_CMD[CMD_W-1:0]) ? jump_r[cur_r] : `MCTA_JMP_STOP;
    jmp_v   = 1'b0;
    jmp_cmd = {CMD_W{1'b0}};
    if (jcode == `MCTA_JMP_NEXT) begin
      jmp_cmd = cur_r + {{(CMD_W-1){1'b0}}, 1'b1};                           // RQ14
      jmp_v   = cmd_ok(jmp_cmd);
    end else if (jcode == `MCTA_JMP_PREV) begin
      jmp_cmd = prev_r;                                                      // RQ14
      jmp_v   = cmd_ok(prev_r);
    end else if (jcode != `MCTA_JMP_STOP && jcode <= `MCTA_JMP_LAST) begin
      jmp_cmd = jcode[CMD_W-1:0];                                            // RQ14
      jmp_v   = cmd_ok(jmp_cmd);
    end
  end

  // The queued request in mode 1 keeps the better ranked of old and new.
  wire             take_new;
  wire             mrg_v;
  wire [CMD_W-1:0] mrg_cmd;
  wire [3:0]       mrg_rank;

  assign take_new = sel_v && (!pend_r || (sel_rank < pend_rank_r));          // RQ12
  assign mrg_v    = pend_r || sel_v;
  assign mrg_cmd  = take_new ? sel_cmd : pend_cmd_r;
  assign mrg_rank = take_new ? sel_rank : pend_rank_r;

  // Sequencer: one global mode rules how a running chain meets new requests.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r      <= 1'b0;
      cur_r       <= {CMD_W{1'b0}};
      prev_r      <= {CMD_W{1'b0}};
      pend_r      <= 1'b0;
      pend_cmd_r  <= {CMD_W{1'b0}};
      pend_rank_r <= `MCTA_RANK_NONE;
      last_rank_r <= `MCTA_RANK_NONE;
      start_r     <= 1'b0;
      abort_r     <= 1'b0;
      chained_r   <= 1'b0;
      num_r       <= {CMD_W{1'b0}};
    end else begin
      start_r <= 1'b0;
      abort_r <= 1'b0;
      if (!busy_r) begin
        if (sel_v) begin
          busy_r      <= 1'b1;
          start_r     <= 1'b1;
          chained_r   <= 1'b0;
          num_r       <= sel_cmd;
          cur_r       <= sel_cmd;
          prev_r      <= {CMD_W{1'b0}};
          last_rank_r <= sel_rank;
        end
      end else begin
        case (mode_r) // RQ8
          `MCTA_MODE_ABORT: begin
            if (sel_v) begin
              abort_r     <= 1'b1;                                           // RQ13
              start_r     <= 1'b1;
              chained_r   <= 1'b0;
              num_r       <= sel_cmd;
              cur_r       <= sel_cmd;
              prev_r      <= cur_r;
              last_rank_r <= sel_rank;
            end else if (cmd_done) begin
              if (jmp_v) begin
                start_r   <= 1'b1;
                chained_r <= 1'b1;
                num_r     <= jmp_cmd;
                cur_r     <= jmp_cmd;
              end else begin
                busy_r    <= 1'b0;
              end
            end
          end
          `MCTA_MODE_AFTER: begin
            // A request that lands in the completion cycle still wins over the jump code.
            if (cmd_done && mrg_v) begin
              start_r     <= 1'b1;                                           // RQ10
              chained_r   <= 1'b1;                                           // RQ11
              num_r       <= mrg_cmd;
              cur_r       <= mrg_cmd;
              prev_r      <= cur_r;
              last_rank_r <= mrg_rank;
              pend_r      <= 1'b0;
              pend_rank_r <= `MCTA_RANK_NONE;
            end else if (cmd_done) begin
              if (jmp_v) begin
                start_r   <= 1'b1;
                chained_r <= 1'b1;
                num_r     <= jmp_cmd;
                cur_r     <= jmp_cmd;
              end else begin
                busy_r    <= 1'b0;
              end
            end else if (take_new) begin
              pend_r      <= 1'b1;                                           // RQ12
              pend_cmd_r  <= sel_cmd;
              pend_rank_r <= sel_rank;
            end
          end
          default: begin
            // Requests during the chain are dropped, including one in the last cycle.
            if (cmd_done) begin                                              // RQ9
              if (jmp_v) begin
                start_r   <= 1'b1;
                chained_r <= 1'b1;
                num_r     <= jmp_cmd;
                cur_r     <= jmp_cmd;
              end else begin
                busy_r    <= 1'b0;
              end
            end
          end
        endcase
        // A queue left over from mode 1 is dropped once the mode changes.
        if (mode_r != `MCTA_MODE_AFTER) begin
          pend_r      <= 1'b0;
          pend_rank_r <= `MCTA_RANK_NONE;
        end
      end
    end
  end

  // Register writes; a software start lasts one cycle after its write.
  integer j;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r     <= `MCTA_RST_MODE;
      sw_cmd_r   <= {CMD_W{1'b0}};
      sw_req_r   <= 1'b0;
      jump_idx_r <= {CMD_W{1'b0}};
      for (j = 0; j < 4; j = j + 1) begin
        evmap_r[j] <= `MCTA_RST_EVMAP;
      end
      for (j = 0; j <= MAX_CMD; j = j + 1) begin
        jump_r[j] <= `MCTA_RST_JUMP;
      end
    end else begin
      sw_req_r <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `MCTA_OFF_MODE: begin
            mode_r <= reg_wdata[1:0];
          end
          `MCTA_OFF_SWSTART: begin
            sw_cmd_r <= reg_wdata[CMD_W-1:0];
            sw_req_r <= 1'b1;                                                // RQ5
          end
          `MCTA_OFF_EVMAP1: begin
            evmap_r[0] <= reg_wdata[MAP_W-1:0];                              // RQ4
          end
          `MCTA_OFF_EVMAP2: begin
            evmap_r[1] <= reg_wdata[MAP_W-1:0];                              // RQ4
          end
          `MCTA_OFF_EVMAP3: begin
            evmap_r[2] <= reg_wdata[MAP_W-1:0];                              // RQ4
          end
          `MCTA_OFF_EVMAP4: begin
            evmap_r[3] <= reg_wdata[MAP_W-1:0];                              // RQ4
          end
          `MCTA_OFF_JUMP: begin
            jump_idx_r <= reg_wdata[CMD_W-1:0];
            if (reg_wdata[CMD_W-1:0] <= MAX_CMD[CMD_W-1:0]) begin
              jump_r[reg_wdata[CMD_W-1:0]] <= reg_wdata[`MCTA_JUMP_MSB:`MCTA_JUMP_LSB];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give zero.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= `MCTA_RST_WORD;
    end else begin
      rdata_r <= `MCTA_RST_WORD;
      if (reg_rd) begin
        case (reg_addr)
          `MCTA_OFF_MODE:    rdata_r <= {30'h0000_0000, mode_r};
          `MCTA_OFF_SWSTART: rdata_r <= {{(32-CMD_W){1'b0}}, sw_cmd_r};
          `MCTA_OFF_EVMAP1:  rdata_r <= {{(32-MAP_W){1'b0}}, evmap_r[0]};
          `MCTA_OFF_EVMAP2:  rdata_r <= {{(32-MAP_W){1'b0}}, evmap_r[1]};
          `MCTA_OFF_EVMAP3:  rdata_r <= {{(32-MAP_W){1'b0}}, evmap_r[2]};
          `MCTA_OFF_EVMAP4:  rdata_r <= {{(32-MAP_W){1'b0}}, evmap_r[3]};
          `MCTA_OFF_JUMP: begin
            rdata_r[CMD_W-1:0] <= jump_idx_r;
            if (jump_idx_r <= MAX_CMD[CMD_W-1:0]) begin
              rdata_r[`MCTA_JUMP_MSB:`MCTA_JUMP_LSB] <= jump_r[jump_idx_r];
            end
          end
          `MCTA_OFF_STATUS: begin
            rdata_r[`MCTA_ST_BUSY] <= busy_r;
            rdata_r[`MCTA_ST_PEND] <= pend_r;
            rdata_r[`MCTA_ST_CUR_LSB +: CMD_W]  <= cur_r;
            rdata_r[`MCTA_ST_PCMD_LSB +: CMD_W] <= pend_cmd_r;
            rdata_r[`MCTA_ST_RANK_LSB +: 4]     <= last_rank_r;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Outputs, all from flip-flops.
  assign reg_rdata   = rdata_r;
  assign cmd_start   = start_r;
  assign cmd_num     = num_r;
  assign cmd_chained = chained_r;
  assign cmd_abort   = abort_r;
  assign cmd_busy    = busy_r;

endmodule // mcta_arbiter

`default_nettype wire

/* File: mcta_arbiter_chk.sv */
// Checker for the trigger arbiter: timing relations seen at the top module's ports.
// Assumes binding to mcta_arbiter and that the mode is only rewritten while idle.
`default_nettype none

module mcta_arbiter_chk #(
  parameter CMD_W = 7
) (
  input wire logic             core_clk,
  input wire logic             sys_rst,
  input wire logic [7:0]       reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [31:0]      reg_rdata,
  input wire logic [3:0]       event_trigger_inputs,
  input wire logic             hw_start_input,
  input wire logic [5:0]       cmd_select_inputs,
  input wire logic             cmd_done,
  input wire logic             cmd_start,
  input wire logic [CMD_W-1:0] cmd_num,
  input wire logic             cmd_chained,
  input wire logic             cmd_abort,
  input wire logic             cmd_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mode_r;

  // Mirror the interrupt mode, since no port shows it directly.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= 2'h0;
    end else if (reg_wr && reg_addr == 8'h00) begin
      mode_r <= reg_wdata[1:0];
    end
  end

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_rd_idle;     !$past(reg_rd) |-> reg_rdata == 32'h0000_0000; endproperty
  property p_abort_start; cmd_abort |-> cmd_start && !cmd_chained; endproperty
  property p_abort_busy;  cmd_abort |-> $past(cmd_busy); endproperty
  property p_abort_mode;  cmd_abort |-> mode_r == 2'h2; endproperty
  property p_fresh_idle;
    (mode_r != 2'h2 && cmd_start && !cmd_chained) |-> !$past(cmd_busy);
  endproperty
  property p_chain_done;  cmd_start && cmd_chained |-> $past(cmd_done); endproperty
  property p_busy_fall;   $fell(cmd_busy) |-> $past(cmd_done); endproperty
  property p_start_busy;  cmd_start |-> cmd_busy; endproperty
  property p_num_hold;    !cmd_start |-> $stable(cmd_num); endproperty
  property p_num_valid;   cmd_start |-> cmd_num != 0 && cmd_num <= 68; endproperty

  a_rd_idle:     assert property (p_rd_idle) else $error("read data not zero when idle");
  a_abort_start: assert property (p_abort_start) else $error("abort without fresh start");
  a_abort_busy:  assert property (p_abort_busy) else $error("abort while idle");
  a_abort_mode:  assert property (p_abort_mode) else $error("abort outside abort mode");
  a_fresh_idle:  assert property (p_fresh_idle) else $error("new chain started while busy");
  a_chain_done:  assert property (p_chain_done) else $error("chained start without done");
  a_busy_fall:   assert property (p_busy_fall) else $error("busy dropped without done");
  a_start_busy:  assert property (p_start_busy) else $error("start without busy");
  a_num_hold:    assert property (p_num_hold) else $error("command number moved");
  a_num_valid:   assert property (p_num_valid) else $error("start of invalid command");

  c_abort:   cover property (cmd_abort);
  c_chained: cover property (cmd_start && cmd_chained);
  c_fall:    cover property ($fell(cmd_busy));
endmodule // mcta_arbiter_chk

bind mcta_arbiter mcta_arbiter_chk #(.CMD_W(CMD_W)) mcta_arbiter_chk_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .event_trigger_inputs(event_trigger_inputs), .hw_start_input(hw_start_input),
  .cmd_select_inputs(cmd_select_inputs), .cmd_done(cmd_done), .cmd_start(cmd_start),
  .cmd_num(cmd_num), .cmd_chained(cmd_chained), .cmd_abort(cmd_abort), .cmd_busy(cmd_busy)
);
`default_nettype wire

/* File: mcta_engine_mdl.sv */
// Behavioural motion engine that runs each started command for a set time.
// Assumes cmd_start is a one-cycle pulse; a new start restarts the run.
`default_nettype none

module mcta_engine_mdl (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       cmd_start,
  input  wire logic [7:0] dly,
  output var  logic       cmd_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r;
  logic       run_r;

  // Count down from each start; an abort simply restarts the count, as a real axis would.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_r <= 1'b0;
      cnt_r <= 8'h00;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      if (cmd_start) begin
        run_r <= 1'b1;
        cnt_r <= dly;
      end else if (run_r && cnt_r == 8'h00) begin
        run_r <= 1'b0;
        cmd_done <= 1'b1;
      end else if (run_r) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule // mcta_engine_mdl
`default_nettype wire

/* File: mcta_arbiter_tb_top.sv */
// Self-checking testbench for the trigger arbiter with a behavioural engine.
// Assumes mcta_arbiter, mcta_engine_mdl and the bound checker are compiled first.
`default_nettype none

module mcta_arbiter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        sys_rst, reg_wr, reg_rd, hw_start_input, cmd_done;
  logic        cmd_start, cmd_chained, cmd_abort, cmd_busy;
  logic [7:0]  reg_addr, dly;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0]  event_trigger_inputs;
  logic [5:0]  cmd_select_inputs;
  logic [6:0]  cmd_num;
  int          bad_count, n_compared, st_cnt;

  mcta_arbiter mcta_arbiter_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .event_trigger_inputs(event_trigger_inputs),
    .hw_start_input(hw_start_input), .cmd_select_inputs(cmd_select_inputs),
    .cmd_done(cmd_done), .cmd_start(cmd_start), .cmd_num(cmd_num),
    .cmd_chained(cmd_chained), .cmd_abort(cmd_abort), .cmd_busy(cmd_busy));
  mcta_engine_mdl mcta_engine_mdl_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .cmd_start(cmd_start), .dly(dly), .cmd_done(cmd_done));

  // The 200 MHz core clock.
  always #2.5 core_clk = ~core_clk;

  // Count every start pulse so masked or dropped requests show as a wrong total.
  always @(posedge core_clk) begin
    if (cmd_start === 1'b1) st_cnt++;
  end

  // Rising edges run the upper two decimal digits of the map, falling edges the lower two.
  function automatic logic [31:0] ev_cmd(input int m, input bit r);
    return r ? 32'((m / 100) % 100) : 32'(m % 100);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so look there and nowhere else.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check(reg_rdata, exp);
  endtask

  task automatic pins(input logic [3:0] ev, input logic hw);
    @(posedge core_clk);
    event_trigger_inputs <= ev;
    hw_start_input <= hw;
  endtask

  // Skip the current cycle first so one pulse is never counted for two expectations.
  task automatic expect_start(input logic [31:0] n, input logic ch, input logic ab);
    int i;
    @(negedge core_clk);
    for (i = 0; i < 100 && cmd_start !== 1'b1; i++) @(negedge core_clk);
    check({cmd_start, cmd_abort, cmd_chained, 22'h0, cmd_num}, {1'b1, ab, ch, 22'h0, n[6:0]});
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 400 && cmd_busy !== 1'b0; i++) @(negedge core_clk);
    check({31'h0, cmd_busy}, 32'h0000_0000);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hang is cut off well beyond the few hundred cycles the sequence needs.
  initial begin
    #100us;
    bad_count++;
    complete_run();
  end

  initial begin
    int m[4];
    int i, s, c;
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    event_trigger_inputs = 4'h0;
    hw_start_input = 1'b0;
    cmd_select_inputs = 6'h00;
    dly = 8'h06;
    void'($urandom(36583));
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    // Reset values, an unmapped address and a mode write read back.
    rd(8'h00, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    wr(8'h00, 32'h0000_0002);
    rd(8'h00, 32'h0000_0002);
    wr(8'h00, 32'h0000_0000);
    // Each event pin gets its own random map; both edges are tried on every pin.
    for (i = 0; i < 4; i++) begin
      m[i] = (($urandom % 68) + 1) * 100 + ($urandom % 68) + 1;
      wr(8'h08 + 8'(4 * i), 32'(m[i]));
    end
    for (i = 0; i < 4; i++) begin
      pins(4'(1 << i), 1'b0);
      expect_start(ev_cmd(m[i], 1), 1'b0, 1'b0);
      wait_idle();
      pins(4'h0, 1'b0);
      expect_start(ev_cmd(m[i], 0), 1'b0, 1'b0);
      wait_idle();
    end
    // Simultaneous sources: only the best rank runs, the rest are masked.
    @(posedge core_clk);
    cmd_select_inputs <= 6'(($urandom % 63) + 1);
    s = st_cnt;
    pins(4'hE, 1'b1);
    expect_start(ev_cmd(m[1], 1), 1'b0, 1'b0);
    wait_idle();
    pins(4'h0, 1'b1);
    expect_start(ev_cmd(m[1], 0), 1'b0, 1'b0);
    wait_idle();
    check(32'(st_cnt - s), 32'h0000_0002);
    pins(4'h0, 1'b0);
    // A one-cycle low would be filtered by the synchroniser, so let the pin settle low first.
    repeat (4) @(posedge core_clk);
    // Hardware start takes its number from the binary select pins.
    c = ($urandom % 63) + 1;
    cmd_select_inputs <= 6'(c);
    pins(4'h0, 1'b1);
    expect_start(32'(c), 1'b0, 1'b0);
    wait_idle();
    pins(4'h0, 1'b0);
    // Mode 0: a software request during a long run is dropped.
    dly = 8'd30;
    s = st_cnt;
    wr(8'h04, 32'h0000_0005);
    expect_start(32'd5, 1'b0, 1'b0);
    wr(8'h04, 32'h0000_0009);
    wait_idle();
    check(32'(st_cnt - s), 32'h0000_0001);
    // Jump chain 10 then next, then an explicit target, then stop.
    dly = 8'h06;
    wr(8'h18, 32'h00A0_000A);
    wr(8'h18, 32'h0003_000B);
    rd(8'h18, 32'h0003_000B);
    wr(8'h04, 32'h0000_000A);
    expect_start(32'd10, 1'b0, 1'b0);
    expect_start(32'd11, 1'b1, 1'b0);
    expect_start(32'd3, 1'b1, 1'b0);
    wait_idle();
    // Mode 1: the better-ranked hardware request is queued and replaces the jump.
    wr(8'h00, 32'h0000_0001);
    dly = 8'd40;
    c = ($urandom % 8) + 30;
    cmd_select_inputs <= 6'(c);
    wr(8'h04, 32'h0000_000A);
    expect_start(32'd10, 1'b0, 1'b0);
    wr(8'h04, 32'h0000_0014);
    pins(4'h0, 1'b1);
    expect_start(32'(c), 1'b1, 1'b0);
    wait_idle();
    pins(4'h0, 1'b0);
    // Mode 2: a request while busy aborts at once.
    wr(8'h00, 32'h0000_0002);
    wr(8'h04, 32'h0000_000A);
    expect_start(32'd10, 1'b0, 1'b0);
    wr(8'h04, 32'h0000_0014);
    expect_start(32'd20, 1'b0, 1'b1);
    wait_idle();
    wr(8'h00, 32'h0000_0000);
    complete_run();
  end
endmodule // mcta_arbiter_tb_top
`default_nettype wire
